// file: hdl/tcc_channel_timer.sv
// Two-channel timer core: external clock modes, input capture, PWM input
// reset slaving, preload/shadow compare and forced output levels.
// Assumes an APB master on core_clk; pins are asynchronous to core_clk.
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "tcc_consts.svh"

module tcc_channel_timer
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins
	input wire logic [1:0] timer_in,
	input wire logic external_trigger_input,
	output logic [1:0] ch_out,
	output logic [1:0] output_reference,
	// Interrupt request
	output logic irq
);

	logic cen_reg;
	tcc_pkg::tcc_slave_t slave_control_reg;
	tcc_pkg::tcc_chcfg_t chcfg_reg [2];
	logic [1:0] capture_flag;
	logic [1:0] overcapture_flag;
	logic [1:0] capture_irq_enable;
	logic [15:0] cnt_reg;
	logic [15:0] preload_reg [2];
	logic [15:0] shadow_reg [2];
	logic [1:0] ti_s1, ti_s2;
	logic etr_s1, etr_s2, etr_d;
	logic [1:0] filtered_input;
	logic [1:0] filt_d;
	logic [1:0] rise, fall;
	logic [1:0] filtered_edge_signal [2];
	logic [1:0] capture_prescaler [2];
	logic [1:0] cap_fire;
	logic [1:0] cmp_match;
	logic [1:0] ev_gen;
	logic [1:0] cap_hit;
	logic [1:0] ccr_rd;
	logic wr_en, rd_en, trig, ext_tick, cnt_tick, cnt_clear;

	// Filter sample count for a code; code 0 takes every sample
	function automatic logic [4:0] filt_len(input logic [3:0] code);
		case (code)
			4'h0: filt_len = 5'h01;
			4'h1: filt_len = 5'h02;
			4'h2: filt_len = 5'h04;
			`TCC_FLT_N8: filt_len = 5'h08;
			default: filt_len = `TCC_FLT_MAX;
		endcase
	endfunction

	// APB: zero-wait, every access completes in its access phase
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;

	function automatic logic addr_ok(input logic [11:0] a);
		addr_ok = (a == `TCC_OFF_CTRL) || (a == `TCC_OFF_SLAVE) ||
			(a == `TCC_OFF_CHCFG) || (a == `TCC_OFF_STATUS) ||
			(a == `TCC_OFF_EVGEN) || (a == `TCC_OFF_CNT) ||
			(a == `TCC_OFF_CCR1) || (a == `TCC_OFF_CCR2) ||
			(a == `TCC_OFF_IEN);
	endfunction

	assign pslverr = psel && penable && !addr_ok(paddr);

	assign ccr_rd[0] = rd_en && (paddr == `TCC_OFF_CCR1);
	assign ccr_rd[1] = rd_en && (paddr == `TCC_OFF_CCR2);
	assign ev_gen = (wr_en && paddr == `TCC_OFF_EVGEN) ?
		pwdata[`TCC_ST_CCF_LO +: 2] : 2'h0;

	// Control registers
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cen_reg <= 1'b0;
			slave_control_reg <= '0;
			chcfg_reg[0] <= '0;
			chcfg_reg[1] <= '0;
			capture_irq_enable <= 2'h0;
		end
		else if (wr_en)
		begin
			if (paddr == `TCC_OFF_CTRL)
				cen_reg <= pwdata[`TCC_CTRL_CEN];
			else if (paddr == `TCC_OFF_SLAVE)
			begin
				slave_control_reg.slave_mode_select <= pwdata[`TCC_SLV_SMS_LO +: 3];
				slave_control_reg.ts <= pwdata[`TCC_SLV_TS_LO +: 3];
				slave_control_reg.ece <= pwdata[`TCC_SLV_ECE];
				slave_control_reg.epol <= pwdata[`TCC_SLV_EPOL];
			end
			else if (paddr == `TCC_OFF_CHCFG)
			begin
				chcfg_reg[0] <= pwdata[`TCC_CH_CEN:0];
				chcfg_reg[1] <= pwdata[`TCC_CH_STRIDE +: 13];
			end
			else if (paddr == `TCC_OFF_IEN)
				capture_irq_enable <= pwdata[`TCC_ST_CCF_LO +: 2];
		end
	end

	// Read mux
	always_comb
	begin
		prdata = `TCC_ZERO32;
		if (paddr == `TCC_OFF_CTRL)
			prdata[`TCC_CTRL_CEN] = cen_reg;
		else if (paddr == `TCC_OFF_SLAVE)
		begin
			prdata[`TCC_SLV_SMS_LO +: 3] = slave_control_reg.slave_mode_select;
			prdata[`TCC_SLV_TS_LO +: 3] = slave_control_reg.ts;
			prdata[`TCC_SLV_ECE] = slave_control_reg.ece;
			prdata[`TCC_SLV_EPOL] = slave_control_reg.epol;
		end
		else if (paddr == `TCC_OFF_CHCFG)
		begin
			prdata[`TCC_CH_CEN:0] = chcfg_reg[0];
			prdata[`TCC_CH_STRIDE +: 13] = chcfg_reg[1];
		end
		else if (paddr == `TCC_OFF_STATUS)
		begin
			prdata[`TCC_ST_CCF_LO +: 2] = capture_flag;
			prdata[`TCC_ST_OVF_LO +: 2] = overcapture_flag;
		end
		else if (paddr == `TCC_OFF_CNT)
			prdata[15:0] = cnt_reg;
		else if (paddr == `TCC_OFF_CCR1)
			prdata[15:0] = preload_reg[0];
		else if (paddr == `TCC_OFF_CCR2)
			prdata[15:0] = preload_reg[1];
		else if (paddr == `TCC_OFF_IEN)
			prdata[`TCC_ST_CCF_LO +: 2] = capture_irq_enable;
	end

	// Pin synchronisers
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ti_s1 <= 2'h0;
			ti_s2 <= 2'h0;
			etr_s1 <= 1'b0;
			etr_s2 <= 1'b0;
			etr_d <= 1'b0;
		end
		else
		begin
			ti_s1 <= timer_in;
			ti_s2 <= ti_s1;
			etr_s1 <= external_trigger_input;
			etr_s2 <= etr_s1;
			etr_d <= etr_s2;
		end
	end

	// Input stage per channel
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_in
			logic [4:0] run_reg;
			logic [1:0] psc_cnt_reg;
			logic src, edge_det;

			// Glitches shorter than the filter length never reach capture
			always_ff @(posedge core_clk or negedge nrst)
			begin
				if (!nrst)
				begin
					filtered_input[g] <= 1'b0;
					run_reg <= 5'h00;
				end
				else if (ti_s2[g] == filtered_input[g])
					run_reg <= 5'h00;
				else if (run_reg + 5'h01 >= filt_len(chcfg_reg[g].flt))
				begin
					filtered_input[g] <= ti_s2[g];
					run_reg <= 5'h00;
				end
				else
					run_reg <= run_reg + 5'h01;
			end

			always_ff @(posedge core_clk or negedge nrst)
			begin
				if (!nrst)
					filt_d[g] <= 1'b0;
				else
					filt_d[g] <= filtered_input[g];
			end

			assign rise[g] = filtered_input[g] && !filt_d[g];
			assign fall[g] = !filtered_input[g] && filt_d[g];
			// Edge signal of input g seen by channel c with c's polarity
			assign filtered_edge_signal[g][0] =
				chcfg_reg[0].pol ? fall[g] : rise[g];
			assign filtered_edge_signal[g][1] =
				chcfg_reg[1].pol ? fall[g] : rise[g];

			// Channel g own input or the neighbour input
			always_comb
			begin
				if (chcfg_reg[g].sel == `TCC_SEL_OWN)
					edge_det = filtered_edge_signal[g][g];
				else if (chcfg_reg[g].sel == `TCC_SEL_OTHER)
					edge_det = filtered_edge_signal[1-g][g];
				else
					edge_det = 1'b0;
			end
			assign src = edge_det && chcfg_reg[g].cen;

			// Prescaler: codes 0 to 2 pass one event in 2**n; code 3 passes one in 4, like code 2
			always_ff @(posedge core_clk or negedge nrst)
			begin
				if (!nrst)
					psc_cnt_reg <= 2'h0;
				else if (chcfg_reg[g].sel == `TCC_SEL_OUT || !chcfg_reg[g].cen)
					psc_cnt_reg <= 2'h0;
				else if (src)
					psc_cnt_reg <= cap_fire[g] ? 2'h0 : psc_cnt_reg + 2'h1;
			end
			assign capture_prescaler[g] = chcfg_reg[g].psc;
			always_comb
			begin
				case (capture_prescaler[g])
					2'h0: cap_fire[g] = src;
					2'h1: cap_fire[g] = src && psc_cnt_reg[0];
					2'h2: cap_fire[g] = src && (psc_cnt_reg == 2'h3);
					default: cap_fire[g] = src && (psc_cnt_reg == 2'h3);
				endcase
			end

			assign cmp_match[g] = (chcfg_reg[g].sel == `TCC_SEL_OUT) &&
				(shadow_reg[g] == cnt_reg);
			assign cap_hit[g] = cap_fire[g] || ev_gen[g];

			// Shadow takes the counter on capture in input modes; in output mode it tracks preload
			always_ff @(posedge core_clk or negedge nrst)
			begin
				if (!nrst)
					shadow_reg[g] <= `TCC_ZERO16;
				else if (chcfg_reg[g].sel != `TCC_SEL_OUT)
				begin
					if (cap_hit[g])
						shadow_reg[g] <= cnt_reg;
				end
				else
					shadow_reg[g] <= preload_reg[g];
			end

			// Copy to preload one cycle after the shadow latch
			logic cap_d;
			always_ff @(posedge core_clk or negedge nrst)
			begin
				if (!nrst)
					cap_d <= 1'b0;
				else
					cap_d <= cap_hit[g] && (chcfg_reg[g].sel != `TCC_SEL_OUT);
			end

			always_ff @(posedge core_clk or negedge nrst)
			begin
				if (!nrst)
					preload_reg[g] <= `TCC_ZERO16;
				else if (cap_d)
					preload_reg[g] <= shadow_reg[g];
				else if (wr_en && paddr == (g ? `TCC_OFF_CCR2 : `TCC_OFF_CCR1)
					&& chcfg_reg[g].sel == `TCC_SEL_OUT)
					preload_reg[g] <= pwdata[15:0];
			end

			// Flags: hardware set wins over software clear
			always_ff @(posedge core_clk or negedge nrst)
			begin
				if (!nrst)
				begin
					capture_flag[g] <= 1'b0;
					overcapture_flag[g] <= 1'b0;
				end
				else
				begin
					if (cap_hit[g] || cmp_match[g])
						capture_flag[g] <= 1'b1;
					else if (ccr_rd[g] || (wr_en && paddr == `TCC_OFF_STATUS
						&& !pwdata[`TCC_ST_CCF_LO + g]))
						capture_flag[g] <= 1'b0;
					if (cap_hit[g] && capture_flag[g] &&
						chcfg_reg[g].sel != `TCC_SEL_OUT)
						overcapture_flag[g] <= 1'b1;
					else if (wr_en && paddr == `TCC_OFF_STATUS &&
						!pwdata[`TCC_ST_OVF_LO + g])
						overcapture_flag[g] <= 1'b0;
				end
			end

			// Output stage: reference active high, polarity last
			always_ff @(posedge core_clk or negedge nrst)
			begin
				if (!nrst)
				begin
					output_reference[g] <= 1'b0;
					ch_out[g] <= 1'b0;
				end
				else
				begin
					if (chcfg_reg[g].sel == `TCC_SEL_OUT &&
						chcfg_reg[g].mode == `TCC_OM_FHIGH)
						output_reference[g] <= 1'b1;
					else if (chcfg_reg[g].sel == `TCC_SEL_OUT &&
						chcfg_reg[g].mode == `TCC_OM_FLOW)
						output_reference[g] <= 1'b0;
					ch_out[g] <= output_reference[g] ^ chcfg_reg[g].pol;
				end
			end
		end
	endgenerate

	// Slave trigger and counter clocking
	always_comb
	begin
		if (slave_control_reg.ts == `TCC_TS_FP1)
			trig = filtered_edge_signal[0][0];
		else if (slave_control_reg.ts == `TCC_TS_FP2)
			trig = filtered_edge_signal[1][1];
		else
			trig = 1'b0;
	end

	assign ext_tick = slave_control_reg.ece &&
		(slave_control_reg.epol ? (!etr_s2 && etr_d) : (etr_s2 && !etr_d));
	assign cnt_clear = slave_control_reg.slave_mode_select == `TCC_SMS_RESET && trig;

	always_comb
	begin
		if (slave_control_reg.slave_mode_select == `TCC_SMS_EXT1)
			cnt_tick = trig;
		else if (slave_control_reg.ece)
			cnt_tick = ext_tick;
		else
			cnt_tick = cen_reg;
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			cnt_reg <= `TCC_ZERO16;
		else if (cnt_clear)
			cnt_reg <= `TCC_ZERO16;
		else if (wr_en && paddr == `TCC_OFF_CNT)
			cnt_reg <= pwdata[15:0];
		else if (cnt_tick && cen_reg)
			cnt_reg <= cnt_reg + `TCC_ONE16;
	end

	assign irq = |(capture_flag & capture_irq_enable);

	// Assertions
	a_capture_sets_flag: assert property (@(posedge core_clk) disable iff (!nrst)
		cap_fire[0] |=> capture_flag[0])
		else $error("capture did not set flag");
	a_overcap_set: assert property (@(posedge core_clk) disable iff (!nrst)
		cap_fire[0] && capture_flag[0] |=> overcapture_flag[0])
		else $error("overcapture not flagged");
	a_capture_copy: assert property (@(posedge core_clk) disable iff (!nrst)
		cap_fire[1] && chcfg_reg[1].sel != `TCC_SEL_OUT
		|=> ##1 preload_reg[1] == $past(cnt_reg, 2))
		else $error("captured value not in preload");
	a_no_cap_disabled: assert property (@(posedge core_clk) disable iff (!nrst)
		!chcfg_reg[0].cen |-> !cap_fire[0])
		else $error("capture while disabled");
	a_force_high_out: assert property (@(posedge core_clk) disable iff (!nrst)
		chcfg_reg[0].sel == `TCC_SEL_OUT && chcfg_reg[0].mode == `TCC_OM_FHIGH
		&& !chcfg_reg[0].pol ##1 $stable(chcfg_reg[0]) |=> ch_out[0])
		else $error("forced active not high");
	a_read_clears: assert property (@(posedge core_clk) disable iff (!nrst)
		ccr_rd[0] && !cap_hit[0] && !cmp_match[0] |=> !capture_flag[0])
		else $error("read did not clear flag");
	a_reset_trigger: assert property (@(posedge core_clk) disable iff (!nrst)
		cnt_clear |=> cnt_reg == `TCC_ZERO16)
		else $error("counter not reset on trigger");
	a_ccr_readonly: assert property (@(posedge core_clk) disable iff (!nrst)
		chcfg_reg[0].sel != `TCC_SEL_OUT && !g_in[0].cap_d
		|=> $stable(preload_reg[0]))
		else $error("input value register written");
	a_evgen_flag: assert property (@(posedge core_clk) disable iff (!nrst)
		ev_gen[1] |=> capture_flag[1])
		else $error("event generation ignored");

endmodule // tcc_channel_timer

// file: hdl/tcc_consts.svh
// Register offsets, field positions, codes and reset values of the timer
// capture/compare block. Assumes inclusion by bare name from hdl/.
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

// Register byte offsets
`define TCC_OFF_CTRL 12'h000
`define TCC_OFF_SLAVE 12'h004
`define TCC_OFF_CHCFG 12'h008
`define TCC_OFF_STATUS 12'h00c
`define TCC_OFF_EVGEN 12'h010
`define TCC_OFF_CNT 12'h014
`define TCC_OFF_CCR1 12'h018
`define TCC_OFF_CCR2 12'h01c
`define TCC_OFF_IEN 12'h020

// Control register bits
`define TCC_CTRL_CEN 0

// Slave control register fields
`define TCC_SLV_SMS_LO 0
`define TCC_SLV_TS_LO 4
`define TCC_SLV_ECE 14
`define TCC_SLV_EPOL 15

// Channel config fields, per channel base 0 or 16
`define TCC_CH_STRIDE 16
`define TCC_CH_SEL_LO 0
`define TCC_CH_PSC_LO 2
`define TCC_CH_FLT_LO 4
`define TCC_CH_MODE_LO 8
`define TCC_CH_POL 11
`define TCC_CH_CEN 12

// Status bits
`define TCC_ST_CCF_LO 1
`define TCC_ST_OVF_LO 9

// Codes
`define TCC_SMS_OFF 3'h0
`define TCC_SMS_RESET 3'h4
`define TCC_SMS_EXT1 3'h7
`define TCC_TS_FP1 3'h5
`define TCC_TS_FP2 3'h6
`define TCC_SEL_OUT 2'h0
`define TCC_SEL_OWN 2'h1
`define TCC_SEL_OTHER 2'h2
`define TCC_OM_FLOW 3'h4
`define TCC_OM_FHIGH 3'h5
`define TCC_FLT_N8 4'h3

`define TCC_ZERO32 32'h0000_0000
`define TCC_ZERO16 16'h0000
`define TCC_ONE16 16'h0001
`define TCC_FLT_MAX 5'h1f

`endif

// file: hdl/tcc_pkg.sv
// Types shared by the timer capture/compare block.
// Assumes tcc_consts.svh for all numeric constants.
package tcc_pkg;

	// Listed from the top bit down so the word lines up with the field map
	typedef struct packed {
		logic cen;
		logic pol;
		logic [2:0] mode;
		logic [3:0] flt;
		logic [1:0] psc;
		logic [1:0] sel;
	} tcc_chcfg_t;

	typedef struct packed {
		logic [2:0] slave_mode_select;
		logic [2:0] ts;
		logic ece;
		logic epol;
	} tcc_slave_t;

endpackage

// file: verif/tcc_pin_model.sv
// Pin-side stand-in: drives the two timer inputs and the trigger pin.
// Assumes core_clk from the bench; pins change just after rising edges.
`timescale 1ns/1ps

module tcc_pin_model
(
	// Clock
	input wire logic core_clk,
	// Pins toward the timer
	output logic [1:0] timer_in,
	output logic external_trigger_input
);
	initial
	begin
		timer_in = 2'h0;
		external_trigger_input = 1'b0;
	end

	// Hold a pin at level v for n cycles; pin 2 is the trigger pin
	task automatic drive(input int ch, input logic v, input int n);
		@(posedge core_clk);
		if (ch == 2)
			external_trigger_input <= v;
		else
			timer_in[ch] <= v;
		repeat (n - 1) @(posedge core_clk);
	endtask

	// Square wave, hi cycles high then lo cycles low, n periods
	task automatic pulses(input int ch, input int hi, input int lo,
		input int n);
		repeat (n)
		begin
			drive(ch, 1'b1, hi);
			drive(ch, 1'b0, lo);
		end
	endtask
endmodule // tcc_pin_model

// file: verif/tb.sv
// Self-checking bench for the timer capture/compare block over APB.
// Assumes hdl/ on the include path and the pin model compiled first.
`timescale 1ns/1ps
`include "tcc_consts.svh"

module tb;
	localparam logic [31:0] m_all = 32'hffff_ffff;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [1:0] timer_in;
	logic external_trigger_input;
	logic [1:0] ch_out;
	logic [1:0] output_reference;
	logic irq;
	logic [31:0] rd;
	logic err;
	int fail_count = 0;
	int samples_checked = 0;

	always #5 core_clk = ~core_clk;

	tcc_channel_timer dut (.core_clk(core_clk), .nrst(nrst),
		.psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .timer_in(timer_in),
		.external_trigger_input(external_trigger_input),
		.ch_out(ch_out), .output_reference(output_reference),
		.irq(irq));

	tcc_pin_model pins (.core_clk(core_clk), .timer_in(timer_in),
		.external_trigger_input(external_trigger_input));

	task automatic wrap_up();
		$display("compares %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Measured periods may land one cycle either way of the pin edge
	task automatic cmp_in(input logic [31:0] got, input logic [31:0] lo,
		input logic [31:0] hi);
		samples_checked++;
		if ((got >= lo && got <= hi) !== 1'b1)
		begin
			fail_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, lo);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int i;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		i = 0;
		do
		begin
			@(posedge core_clk);
			i++;
		end
		while (pready !== 1'b1 && i < 50);
		if (i >= 50)
		begin
			fail_count++;
			wrap_up();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		cmp(rd & m, exp);
	endtask

	function automatic logic [31:0] chf(input logic [1:0] s,
		input logic [3:0] f, input logic [2:0] md, input logic p,
		input logic e);
		return (32'(s) << `TCC_CH_SEL_LO) | (32'(f) << `TCC_CH_FLT_LO) |
			(32'(md) << `TCC_CH_MODE_LO) | (32'(p) << `TCC_CH_POL) |
			(32'(e) << `TCC_CH_CEN);
	endfunction

	function automatic logic [31:0] slv(input logic [2:0] sm,
		input logic [2:0] ts, input logic ece);
		return (32'(sm) << `TCC_SLV_SMS_LO) | (32'(ts) << `TCC_SLV_TS_LO) |
			(32'(ece) << `TCC_SLV_ECE);
	endfunction

	initial
	begin
		logic [15:0] v;
		logic [31:0] a;
		int h;
		int l;
		int n;
		void'($urandom(32'hae2ee4ae));
		repeat (10) @(posedge core_clk);
		nrst <= 1'b1;
		// Unmapped word is refused and reads zero
		apb(1'b0, 12'h024, 32'h0);
		cmp(rd, 32'h0);
		cmp(32'(err), 32'h1);
		for (int k = 0; k < 4; k++)
		begin
			// Both channels forced alike, with opposite polarities
			wr(`TCC_OFF_CHCFG, chf(`TCC_SEL_OUT, 4'h0,
				k[1] ? `TCC_OM_FHIGH : `TCC_OM_FLOW, k[0], 1'b0) |
				(chf(`TCC_SEL_OUT, 4'h0, k[1] ? `TCC_OM_FHIGH : `TCC_OM_FLOW,
				!k[0], 1'b0) << `TCC_CH_STRIDE));
			repeat (3) @(posedge core_clk);
			cmp(32'(output_reference), 32'({2{k[1]}}));
			cmp(32'(ch_out), 32'({k[1] ^ !k[0], k[1] ^ k[0]}));
		end
		// Counter held still so the match persists; clear the reset match
		v = 16'($urandom) | 16'h0001;
		wr(`TCC_OFF_CNT, 32'(v));
		wr(`TCC_OFF_STATUS, 32'h0);
		rdchk(`TCC_OFF_STATUS, 32'h2, 32'h0);
		wr(`TCC_OFF_CCR1, 32'(v));
		wr(`TCC_OFF_IEN, 32'h2);
		rdchk(`TCC_OFF_CCR1, m_all, 32'(v));
		rdchk(`TCC_OFF_STATUS, 32'h2, 32'h2);
		cmp(32'(irq), 32'h1);
		wr(`TCC_OFF_IEN, 32'h0);
		@(posedge core_clk);
		cmp(32'(irq), 32'h0);
		wr(`TCC_OFF_CCR1, 32'(v + 16'h1));
		wr(`TCC_OFF_STATUS, 32'h0);
		rdchk(`TCC_OFF_STATUS, 32'h2, 32'h0);
		// Software capture events on an input channel
		wr(`TCC_OFF_CHCFG, chf(`TCC_SEL_OWN, 4'h0, 3'h0, 1'b0, 1'b1));
		wr(`TCC_OFF_IEN, 32'h2);
		v = 16'($urandom);
		wr(`TCC_OFF_CNT, 32'(v));
		wr(`TCC_OFF_CCR1, 32'(~v));
		wr(`TCC_OFF_EVGEN, 32'h2);
		rdchk(`TCC_OFF_STATUS, 32'h606, 32'h2);
		cmp(32'(irq), 32'h1);
		rdchk(`TCC_OFF_CCR1, m_all, 32'(v));
		rdchk(`TCC_OFF_STATUS, 32'h606, 32'h0);
		wr(`TCC_OFF_EVGEN, 32'h2);
		wr(`TCC_OFF_EVGEN, 32'h2);
		rdchk(`TCC_OFF_STATUS, 32'h606, 32'h202);
		wr(`TCC_OFF_STATUS, 32'h200);
		rdchk(`TCC_OFF_STATUS, 32'h606, 32'h200);
		wr(`TCC_OFF_STATUS, 32'h0);
		rdchk(`TCC_OFF_STATUS, 32'h606, 32'h0);
		// Pin captures through the 8-sample filter
		v = 16'($urandom);
		wr(`TCC_OFF_CNT, 32'(v));
		wr(`TCC_OFF_CHCFG, chf(`TCC_SEL_OWN, `TCC_FLT_N8, 3'h0, 1'b0, 1'b0));
		pins.pulses(0, 12, 20, 1);
		rdchk(`TCC_OFF_STATUS, 32'h2, 32'h0);
		wr(`TCC_OFF_CHCFG, chf(`TCC_SEL_OWN, `TCC_FLT_N8, 3'h0, 1'b0, 1'b1));
		pins.pulses(0, 5, 20, 1);
		rdchk(`TCC_OFF_STATUS, 32'h2, 32'h0);
		pins.pulses(0, 12, 20, 1);
		rdchk(`TCC_OFF_STATUS, 32'h2, 32'h2);
		rdchk(`TCC_OFF_CCR1, m_all, 32'(v));
		v = 16'($urandom);
		wr(`TCC_OFF_CNT, 32'(v));
		wr(`TCC_OFF_CHCFG, chf(`TCC_SEL_OWN, `TCC_FLT_N8, 3'h0, 1'b1, 1'b1));
		pins.drive(0, 1'b1, 20);
		rdchk(`TCC_OFF_STATUS, 32'h2, 32'h0);
		pins.drive(0, 1'b0, 20);
		rdchk(`TCC_OFF_STATUS, 32'h2, 32'h2);
		rdchk(`TCC_OFF_CCR1, m_all, 32'(v));
		pins.pulses(0, 12, 20, 2);
		rdchk(`TCC_OFF_STATUS, 32'h606, 32'h202);
		wr(`TCC_OFF_STATUS, 32'h0);
		// Divide-by-two prescaler: two rising edges give one capture
		wr(`TCC_OFF_CHCFG, chf(`TCC_SEL_OWN, 4'h0, 3'h0, 1'b0, 1'b1) |
			(32'h1 << `TCC_CH_PSC_LO));
		pins.pulses(0, 4, 6, 2);
		rdchk(`TCC_OFF_STATUS, 32'h606, 32'h2);
		wr(`TCC_OFF_STATUS, 32'h0);
		// External clock from the filtered channel 1 edge, then the pin
		n = 3 + $urandom % 8;
		wr(`TCC_OFF_CTRL, 32'h1);
		wr(`TCC_OFF_CHCFG, chf(`TCC_SEL_OWN, 4'h0, 3'h0, 1'b0, 1'b0));
		wr(`TCC_OFF_SLAVE, slv(`TCC_SMS_EXT1, `TCC_TS_FP1, 1'b0));
		wr(`TCC_OFF_CNT, 32'h0);
		pins.pulses(0, 4, 6, n);
		rdchk(`TCC_OFF_CNT, 32'hffff, 32'(n));
		wr(`TCC_OFF_SLAVE, slv(`TCC_SMS_OFF, 3'h0, 1'b1));
		wr(`TCC_OFF_CNT, 32'h0);
		pins.pulses(2, 4, 6, n);
		rdchk(`TCC_OFF_CNT, 32'hffff, 32'(n));
		wr(`TCC_OFF_SLAVE, slv(`TCC_SMS_OFF, 3'h0, 1'b0));
		apb(1'b0, `TCC_OFF_CNT, 32'h0);
		a = rd;
		rdchk(`TCC_OFF_CNT, 32'hffff, (a + 32'h3) & 32'hffff);
		// Period and high time of a random wave on one pin
		h = 6 + $urandom % 20;
		l = 6 + $urandom % 20;
		wr(`TCC_OFF_CHCFG, chf(`TCC_SEL_OWN, 4'h0, 3'h0, 1'b0, 1'b1) |
			(chf(`TCC_SEL_OTHER, 4'h0, 3'h0, 1'b1, 1'b1) << 16));
		wr(`TCC_OFF_SLAVE, slv(`TCC_SMS_RESET, `TCC_TS_FP1, 1'b0));
		pins.pulses(0, h, l, 4);
		apb(1'b0, `TCC_OFF_CCR1, 32'h0);
		cmp_in(rd, h + l - 1, h + l + 1);
		apb(1'b0, `TCC_OFF_CCR2, 32'h0);
		cmp_in(rd, h - 1, h + 1);
		wrap_up();
	end
endmodule // tb
